// ### dv/ctxsc_regs_sva.sv
// Assertion checker for the calibration and status block.
`timescale 1ns/100ps
module ctxsc_regs_sva #(
    parameter int NUM_TX = 2,
    parameter int NUM_RX = 4,
    parameter int CAL_LEN_SHIFT = 0
) (
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire logic I_REG_RD,
    input wire logic O_REG_RVALID,
    input wire logic [NUM_TX*NUM_RX-1:0] I_RX_ENABLED,
    input wire logic [NUM_TX-1:0] I_FWD_SYNC_EN,
    input wire logic [NUM_TX-1:0] I_STREAMS_SYNCED,
    input wire logic [NUM_TX-1:0] I_TX_ERROR,
    input wire logic [NUM_TX-1:0] I_HS_BUSY,
    input wire logic [NUM_TX-1:0] O_CAL_ACTIVE,
    input wire logic [NUM_TX-1:0] O_CAL_DATA,
    input wire logic [NUM_TX-1:0] O_HS_HOLD,
    input wire logic [NUM_TX-1:0] O_TX_PASS,
    input wire logic [NUM_TX-1:0] O_TX_SYNC
);
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RST_N);
    sequence s_rise;
        !O_CAL_ACTIVE[0] ##1 O_CAL_ACTIVE[0];
    endsequence
    sequence s_run;
        O_CAL_ACTIVE[0] ##1 O_CAL_ACTIVE[0];
    endsequence
    property p_rv;
        I_REG_RD |=> O_REG_RVALID;
    endproperty
    a_rv: assert property (p_rv) else $error("read not answered");
    property p_norv;
        !I_REG_RD |=> !O_REG_RVALID;
    endproperty
    a_norv: assert property (p_norv) else $error("stray valid");
    property p_sync;
        I_FWD_SYNC_EN[0] && I_STREAMS_SYNCED[0] |=> O_TX_SYNC[0];
    endproperty
    a_sync: assert property (p_sync) else $error("sync missing");
    property p_nosync;
        !I_FWD_SYNC_EN[0] |=> !O_TX_SYNC[0];
    endproperty
    a_nosync: assert property (p_nosync) else $error("sync set");
    property p_err;
        I_TX_ERROR[0] && !I_FWD_SYNC_EN[0] |=> !O_TX_PASS[0];
    endproperty
    a_err: assert property (p_err) else $error("pass kept");
    property p_noen;
        I_RX_ENABLED[3:0] == 4'h0 |=> !O_TX_PASS[0];
    endproperty
    a_noen: assert property (p_noen) else $error("pass no port");
    property p_idle;
        !O_CAL_ACTIVE[0] |-> !O_CAL_DATA[0];
    endproperty
    a_idle: assert property (p_idle) else $error("idle data");
    property p_alt;
        s_run |-> O_CAL_DATA[0] != $past(O_CAL_DATA[0]);
    endproperty
    a_alt: assert property (p_alt) else $error("no toggle");
    property p_hold;
        O_CAL_ACTIVE[0] |-> O_HS_HOLD[0];
    endproperty
    a_hold: assert property (p_hold) else $error("hold low");
    property p_quiet;
        s_rise |-> !$past(I_HS_BUSY[0], 3);
    endproperty
    a_quiet: assert property (p_quiet) else $error("cal in HS");
    property p_len;
        s_rise |-> O_CAL_ACTIVE[0] [*8];
    endproperty
    a_len: assert property (p_len) else $error("cal short");
endmodule
bind ctxsc_regs ctxsc_regs_sva #(.NUM_TX(NUM_TX), .NUM_RX(NUM_RX),
    .CAL_LEN_SHIFT(CAL_LEN_SHIFT)) u_ctxsc_regs_sva (.I_CLK(I_CLK),
    .I_RST_N(I_RST_N), .I_REG_RD(I_REG_RD), .O_REG_RVALID(O_REG_RVALID),
    .I_RX_ENABLED(I_RX_ENABLED), .I_FWD_SYNC_EN(I_FWD_SYNC_EN),
    .I_STREAMS_SYNCED(I_STREAMS_SYNCED), .I_TX_ERROR(I_TX_ERROR),
    .I_HS_BUSY(I_HS_BUSY), .O_CAL_ACTIVE(O_CAL_ACTIVE),
    .O_CAL_DATA(O_CAL_DATA), .O_HS_HOLD(O_HS_HOLD),
    .O_TX_PASS(O_TX_PASS), .O_TX_SYNC(O_TX_SYNC));

// ### dv/ctxsc_rx_model.sv
// Receiver model that measures calibration sequences on one lane.
`timescale 1ns/100ps
module ctxsc_rx_model (
    input wire logic i_clk,
    input wire logic i_act,
    input wire logic i_dat,
    output logic o_done,
    output logic [15:0] o_len,
    output logic o_first,
    output logic o_alt_ok
);
    logic act_q = 1'b0;
    logic last_q = 1'b0;
    initial o_done = 1'b0;
    // Length and pattern are judged only after the lane falls idle.
    always_ff @(posedge i_clk) begin
        act_q <= i_act;
        last_q <= i_dat;
        o_done <= act_q && !i_act;
        if (i_act && !act_q) begin
            o_len <= 16'h0001;
            o_first <= i_dat;
            o_alt_ok <= 1'b1;
        end else if (i_act) begin
            o_len <= o_len + 16'h0001;
            if (i_dat == last_q) begin
                o_alt_ok <= 1'b0;
            end
        end
    end
endmodule

// ### dv/tb_ctxsc_regs.sv
// Self-checking testbench for the calibration and status block.
`timescale 1ns/100ps
module tb_ctxsc_regs;
    localparam int SH = 6;
    localparam int EXP [4] = '{10, 12, 14, 15};
    logic I_CLK = 1'b0;
    logic I_RST_N = 1'b0;
    logic I_REG_WR = 1'b0;
    logic I_REG_RD = 1'b0;
    logic [7:0] I_REG_ADDR = 8'h00;
    logic [7:0] I_REG_WDATA = 8'h00;
    logic [7:0] O_REG_RDATA;
    logic O_REG_RVALID;
    logic [7:0] I_RX_VALID = 8'h00;
    logic [7:0] I_RX_ENABLED = 8'h00;
    logic [1:0] I_FWD_SYNC_EN = 2'h0;
    logic [1:0] I_STREAMS_SYNCED = 2'h0;
    logic [1:0] I_TX_ERROR = 2'h0;
    logic [1:0] I_HS_BUSY = 2'h0;
    logic [1:0] I_FRAME_END = 2'h0;
    logic [1:0] I_TX_INIT = 2'h0;
    logic [1:0] O_CAL_ACTIVE;
    logic [1:0] O_CAL_DATA;
    logic [1:0] O_HS_HOLD;
    logic [1:0] O_TX_PASS;
    logic [1:0] O_TX_SYNC;
    logic done;
    logic [15:0] len;
    logic first;
    logic alt;
    int mismatches = 0;
    int total_checks = 0;
    int ncal = 0;
    logic [7:0] rq [$];
    logic [16:0] cq [$];
    ctxsc_regs #(.NUM_TX(2), .NUM_RX(4), .CAL_LEN_SHIFT(SH)) u_ctxsc_regs (
        .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_REG_WR(I_REG_WR),
        .I_REG_RD(I_REG_RD), .I_REG_ADDR(I_REG_ADDR),
        .I_REG_WDATA(I_REG_WDATA), .O_REG_RDATA(O_REG_RDATA),
        .O_REG_RVALID(O_REG_RVALID), .I_RX_VALID(I_RX_VALID),
        .I_RX_ENABLED(I_RX_ENABLED), .I_FWD_SYNC_EN(I_FWD_SYNC_EN),
        .I_STREAMS_SYNCED(I_STREAMS_SYNCED), .I_TX_ERROR(I_TX_ERROR),
        .I_HS_BUSY(I_HS_BUSY), .I_FRAME_END(I_FRAME_END),
        .I_TX_INIT(I_TX_INIT), .O_CAL_ACTIVE(O_CAL_ACTIVE),
        .O_CAL_DATA(O_CAL_DATA), .O_HS_HOLD(O_HS_HOLD),
        .O_TX_PASS(O_TX_PASS), .O_TX_SYNC(O_TX_SYNC));
    ctxsc_rx_model u_ctxsc_rx_model (.i_clk(I_CLK), .i_act(O_CAL_ACTIVE[0]),
        .i_dat(O_CAL_DATA[0]), .o_done(done), .o_len(len), .o_first(first),
        .o_alt_ok(alt));
    initial begin
        forever #20 I_CLK = ~I_CLK;
    end
    task automatic chk(input string n, input logic [16:0] s,
        input logic [16:0] e);
        total_checks++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge I_CLK);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        I_REG_WR = 1'b1;
        I_REG_ADDR = a;
        I_REG_WDATA = d;
        cyc(1);
        I_REG_WR = 1'b0;
        // An idle edge keeps the strobe from dropping and rising in one step.
        cyc(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        rq.push_back(e);
        I_REG_RD = 1'b1;
        I_REG_ADDR = a;
        cyc(1);
        I_REG_RD = 1'b0;
        cyc(1);
    endtask
    // A sequence is never longer than 512 bits here, so 3000 is ample.
    task automatic wcal();
        int k;
        for (k = 0; k < 3000 && cq.size() != 0; k++) cyc(1);
        if (cq.size() != 0) begin
            mismatches++;
            summarize();
        end
    endtask
    always @(negedge I_CLK) begin
        if (O_REG_RVALID === 1'b1) begin
            if (rq.size() == 0) chk("rvalid", 17'h0_0001, 17'h0_0000);
            else chk("rdata", O_REG_RDATA, rq.pop_front());
        end
        if (done === 1'b1) begin
            ncal++;
            if (cq.size() == 0) chk("cal", 17'h0_0001, 17'h0_0000);
            else chk("cal", {first, len}, cq.pop_front());
            chk("alt", alt, 17'h0_0001);
        end
    end
    initial begin
        int i;
        int m;
        int p;
        logic inv;
        logic ep;
        logic [3:0] v;
        logic [3:0] en;
        logic [7:0] d;
        void'($urandom(1113));
        cyc(16);
        I_RST_N = 1'b1;
        cyc(1);
        for (i = 0; i < 4; i++) rd(8'h32 + 8'(i), 8'h00);
        rd(8'h40, 8'h00);
        wr(8'h32, 8'h13);
        rd(8'h35, 8'h10);
        wr(8'h34, 8'h3D);
        wr(8'h32, 8'h01);
        wr(8'h34, 8'hC8);
        rd(8'h34, 8'h08);
        wr(8'h32, 8'h10);
        rd(8'h34, 8'h3D);
        wr(8'h32, 8'h01);
        for (i = 0; i < 4; i++) begin
            inv = 1'($urandom_range(1));
            d = {2'b00, 2'(i), 1'b0, inv, 2'b10};
            cq.push_back({inv, 16'(1 << (EXP[i] - SH))});
            I_HS_BUSY = 2'b01;
            wr(8'h34, d);
            cyc($urandom_range(1, 20));
            chk("quiet", O_CAL_ACTIVE, 17'h0_0000);
            I_HS_BUSY = 2'b00;
            wcal();
            cyc(3);
            rd(8'h34, d & 8'hFD);
        end
        // Two frame ends under traffic must merge into one sequence.
        wr(8'h34, 8'h01);
        cq.push_back({1'b0, 16'(1 << (10 - SH))});
        I_HS_BUSY = 2'b01;
        for (i = 0; i < 2; i++) begin
            I_FRAME_END = 2'b01;
            cyc(1);
            I_FRAME_END = 2'b00;
            cyc(3);
        end
        I_HS_BUSY = 2'b00;
        wcal();
        wr(8'h34, 8'h00);
        I_FRAME_END = 2'b01;
        cyc(1);
        I_FRAME_END = 2'b00;
        cyc(40);
        wr(8'h33, 8'h40);
        cq.push_back({1'b0, 16'(1 << (10 - SH))});
        I_TX_INIT = 2'b01;
        cyc(1);
        I_TX_INIT = 2'b00;
        cyc(1);
        chk("hold", O_HS_HOLD[0], 17'h0_0001);
        wcal();
        rd(8'h33, 8'h40);
        wr(8'h32, 8'h03);
        for (m = 0; m < 2; m++) begin
            wr(8'h34, (m == 1) ? 8'h08 : 8'h00);
            for (i = 0; i < 40; i++) begin
                I_RX_VALID = 8'($urandom);
                I_RX_ENABLED = 8'($urandom);
                I_FWD_SYNC_EN = 2'($urandom);
                I_STREAMS_SYNCED = 2'($urandom);
                I_TX_ERROR = 2'($urandom);
                cyc(1);
                for (p = 0; p < 2; p++) begin
                    en = I_RX_ENABLED[p*4 +: 4];
                    v = I_RX_VALID[p*4 +: 4] & en;
                    ep = (m == 1) ? (en != 4'h0 && v == en) : (v != 4'h0);
                    if (!I_FWD_SYNC_EN[p] && I_TX_ERROR[p]) ep = 1'b0;
                    chk("pass", O_TX_PASS[p], ep);
                    chk("sync", O_TX_SYNC[p],
                        I_FWD_SYNC_EN[p] & I_STREAMS_SYNCED[p]);
                end
            end
        end
        I_RX_VALID = 8'h11;
        I_RX_ENABLED = 8'h11;
        I_FWD_SYNC_EN = 2'h3;
        I_STREAMS_SYNCED = 2'h3;
        I_TX_ERROR = 2'h0;
        cyc(2);
        wr(8'h32, 8'h10);
        rd(8'h35, 8'h13);
        cyc(4);
        chk("ncal", ncal, 17'h0_0006);
        summarize();
    end
endmodule

// ### hw/ctxsc_cal_seq.sv
// Serial generator of one skew calibration sequence of selectable length.
`timescale 1ns/100ps
`include "ctxsc_defs.svh"
module ctxsc_cal_seq #(
    parameter int LEN_SHIFT = 0
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_start,
    input wire logic [1:0] i_len_code,
    input wire logic i_invert,
    output logic o_active,
    output logic o_data,
    output logic o_done
);
    ctxsc_pkg::ctxsc_cal_state_t state_q;
    logic [15:0] cnt_q;
    logic [15:0] last_q;
    logic [4:0] exp_d;
    logic inv_q;

    always_comb begin
        case (i_len_code)
            2'b00: exp_d = `CTXSC_CAL_EXP_CODE0;
            2'b01: exp_d = `CTXSC_CAL_EXP_CODE1;
            2'b10: exp_d = `CTXSC_CAL_EXP_CODE2;
            default: exp_d = `CTXSC_CAL_EXP_CODE3;
        endcase
    end

    // One bit per clock; length is sampled at start so a rewrite mid-sequence
    // cannot cut a sequence short.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_q <= ctxsc_pkg::CAL_IDLE;
            cnt_q <= 16'h0000;
            last_q <= 16'h0000;
            inv_q <= 1'b0;
        end else begin
            case (state_q)
                ctxsc_pkg::CAL_IDLE: begin
                    if (i_start) begin
                        last_q <= 16'((17'h1_0000 >> (5'd16 - exp_d))
                            >> LEN_SHIFT) - 16'h0001;
                        cnt_q <= 16'h0000;
                        inv_q <= i_invert;
                        state_q <= ctxsc_pkg::CAL_RUN;
                    end
                end
                ctxsc_pkg::CAL_RUN: begin
                    if (cnt_q == last_q) begin
                        state_q <= ctxsc_pkg::CAL_LAST;
                    end else begin
                        cnt_q <= cnt_q + 16'h0001;
                    end
                end
                default: state_q <= ctxsc_pkg::CAL_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_active <= 1'b0;
            o_data <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_active <= (state_q == ctxsc_pkg::CAL_RUN);
            o_data <= (state_q == ctxsc_pkg::CAL_RUN) &
                (cnt_q[0] ^ inv_q);
            o_done <= (state_q == ctxsc_pkg::CAL_LAST);
        end
    end
endmodule

// ### hw/ctxsc_defs.svh
// Register offsets, field positions, reset values and counts for the block.
`ifndef CTXSC_DEFS_SVH
`define CTXSC_DEFS_SVH

`define CTXSC_ADDR_PORT_SEL 8'h32
`define CTXSC_ADDR_CTL 8'h33
`define CTXSC_ADDR_CTL2 8'h34
`define CTXSC_ADDR_STS 8'h35

`define CTXSC_RST_PORT_SEL 8'h00
`define CTXSC_RST_CTL 8'h00
`define CTXSC_RST_CTL2 8'h00
`define CTXSC_RD_ZERO 8'h00

`define CTXSC_SEL_READ_BIT 4
`define CTXSC_SEL_WR1_BIT 1
`define CTXSC_SEL_WR0_BIT 0

`define CTXSC_CTL_INIT_CAL_BIT 6

`define CTXSC_CTL2_MASK 8'h3F
`define CTXSC_CTL2_LEN_HI 5
`define CTXSC_CTL2_LEN_LO 4
`define CTXSC_CTL2_PASS_MODE_BIT 3
`define CTXSC_CTL2_INV_BIT 2
`define CTXSC_CTL2_SINGLE_BIT 1
`define CTXSC_CTL2_PERIODIC_BIT 0

`define CTXSC_STS_PORT_NUM_BIT 4
`define CTXSC_STS_SYNC_BIT 1
`define CTXSC_STS_PASS_BIT 0

`define CTXSC_CAL_EXP_CODE0 5'd10
`define CTXSC_CAL_EXP_CODE1 5'd12
`define CTXSC_CAL_EXP_CODE2 5'd14
`define CTXSC_CAL_EXP_CODE3 5'd15

`define CTXSC_NUM_TX 2
`define CTXSC_NUM_RX 4

`endif

// ### hw/ctxsc_pass.sv
// Combines receive port valid flags into the transmit pass indication.
`timescale 1ns/100ps
module ctxsc_pass #(
    parameter int NUM_RX = 4
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [NUM_RX-1:0] i_rx_valid,
    input wire logic [NUM_RX-1:0] i_rx_enabled,
    input wire logic i_all_mode,
    input wire logic i_sync_fwd,
    input wire logic i_tx_error,
    output logic o_pass
);
    logic any_ok;
    logic all_ok;
    logic comb_ok;

    assign any_ok = |(i_rx_valid & i_rx_enabled);
    assign all_ok = (|i_rx_enabled) &
        (&(i_rx_valid | ~i_rx_enabled));
    assign comb_ok = i_all_mode ? all_ok : any_ok;

    // Synchronized forwarding only reports availability; an error that stops
    // delivery matters only in asynchronous forwarding.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_pass <= 1'b0;
        end else if (i_sync_fwd) begin
            o_pass <= comb_ok;
        end else begin
            o_pass <= comb_ok & ~i_tx_error;
        end
    end
endmodule

// ### hw/ctxsc_pkg.sv
// Types shared by the skew calibration and status block.
package ctxsc_pkg;

    typedef enum logic [1:0] {
        CAL_IDLE = 2'b00,
        CAL_RUN = 2'b01,
        CAL_LAST = 2'b11
    } ctxsc_cal_state_t;

    typedef enum logic [1:0] {
        SRC_NONE = 2'b00,
        SRC_INIT = 2'b01,
        SRC_PERIODIC = 2'b11,
        SRC_SINGLE = 2'b10
    } ctxsc_cal_src_t;

endpackage

// ### hw/ctxsc_regs.sv
// Per transmit port calibration control, status and port select registers.
`timescale 1ns/100ps
`include "ctxsc_defs.svh"
module ctxsc_regs #(
    parameter int NUM_TX = `CTXSC_NUM_TX,
    parameter int NUM_RX = `CTXSC_NUM_RX,
    parameter int CAL_LEN_SHIFT = 0
) (
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [7:0] I_REG_WDATA,
    output logic [7:0] O_REG_RDATA,
    output logic O_REG_RVALID,
    input wire logic [NUM_TX*NUM_RX-1:0] I_RX_VALID,
    input wire logic [NUM_TX*NUM_RX-1:0] I_RX_ENABLED,
    input wire logic [NUM_TX-1:0] I_FWD_SYNC_EN,
    input wire logic [NUM_TX-1:0] I_STREAMS_SYNCED,
    input wire logic [NUM_TX-1:0] I_TX_ERROR,
    input wire logic [NUM_TX-1:0] I_HS_BUSY,
    input wire logic [NUM_TX-1:0] I_FRAME_END,
    input wire logic [NUM_TX-1:0] I_TX_INIT,
    output logic [NUM_TX-1:0] O_CAL_ACTIVE,
    output logic [NUM_TX-1:0] O_CAL_DATA,
    output logic [NUM_TX-1:0] O_HS_HOLD,
    output logic [NUM_TX-1:0] O_TX_PASS,
    output logic [NUM_TX-1:0] O_TX_SYNC
);
    logic [7:0] port_sel_q;
    logic read_port;
    logic [NUM_TX-1:0] wr_en;
    logic wr_sel;
    logic wr_ctl;
    logic wr_ctl2;
    logic [7:0] ctl2_q [NUM_TX];
    logic [NUM_TX-1:0] init_en_q;
    logic [NUM_TX-1:0] sync_q;
    logic [7:0] rdata_d;

    assign wr_sel = I_REG_WR & (I_REG_ADDR == `CTXSC_ADDR_PORT_SEL);
    assign wr_ctl = I_REG_WR & (I_REG_ADDR == `CTXSC_ADDR_CTL);
    assign wr_ctl2 = I_REG_WR & (I_REG_ADDR == `CTXSC_ADDR_CTL2);
    assign read_port = port_sel_q[`CTXSC_SEL_READ_BIT];
    assign wr_en[0] = port_sel_q[`CTXSC_SEL_WR0_BIT];
    assign wr_en[1] = port_sel_q[`CTXSC_SEL_WR1_BIT];

    // Only the documented selector bits are stored; the rest read as zero.
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            port_sel_q <= `CTXSC_RST_PORT_SEL;
        end else if (wr_sel) begin
            port_sel_q <= 8'h00;
            port_sel_q[`CTXSC_SEL_READ_BIT] <=
                I_REG_WDATA[`CTXSC_SEL_READ_BIT];
            port_sel_q[`CTXSC_SEL_WR1_BIT] <=
                I_REG_WDATA[`CTXSC_SEL_WR1_BIT];
            port_sel_q[`CTXSC_SEL_WR0_BIT] <=
                I_REG_WDATA[`CTXSC_SEL_WR0_BIT];
        end
    end

    genvar p;
    for (p = 0; p < NUM_TX; p++) begin : g_tx
        logic init_pend_q;
        logic per_pend_q;
        logic launch;
        logic launch_q;
        logic run_q;
        logic hold_q;
        logic seq_active;
        logic seq_done;
        logic single_req;
        ctxsc_pkg::ctxsc_cal_src_t src_d;
        ctxsc_pkg::ctxsc_cal_src_t src_q;

        assign single_req = ctl2_q[p][`CTXSC_CTL2_SINGLE_BIT];

        // A sequence is launched only between packets and never while one is
        // still running or just ending, so requests cannot double up.
        assign launch = ~I_HS_BUSY[p] & ~run_q &
            (init_pend_q | per_pend_q | single_req);

        // Initial calibration goes first since HS data waits on it.
        always_comb begin
            if (init_pend_q) begin
                src_d = ctxsc_pkg::SRC_INIT;
            end else if (per_pend_q) begin
                src_d = ctxsc_pkg::SRC_PERIODIC;
            end else if (single_req) begin
                src_d = ctxsc_pkg::SRC_SINGLE;
            end else begin
                src_d = ctxsc_pkg::SRC_NONE;
            end
        end

        always_ff @(posedge I_CLK) begin
            if (!I_RST_N) begin
                ctl2_q[p] <= `CTXSC_RST_CTL2;
            end else if (wr_ctl2 && wr_en[p]) begin
                ctl2_q[p] <= I_REG_WDATA & `CTXSC_CTL2_MASK;
            end else if (seq_done && src_q == ctxsc_pkg::SRC_SINGLE) begin
                ctl2_q[p][`CTXSC_CTL2_SINGLE_BIT] <= 1'b0;
            end
        end

        always_ff @(posedge I_CLK) begin
            if (!I_RST_N) begin
                init_en_q[p] <= `CTXSC_RST_CTL == 8'h00 ? 1'b0 : 1'b1;
            end else if (wr_ctl && wr_en[p]) begin
                init_en_q[p] <= I_REG_WDATA[`CTXSC_CTL_INIT_CAL_BIT];
            end
        end

        always_ff @(posedge I_CLK) begin
            if (!I_RST_N) begin
                init_pend_q <= 1'b0;
            end else if (I_TX_INIT[p] && init_en_q[p]) begin
                init_pend_q <= 1'b1;
            end else if (seq_done && src_q == ctxsc_pkg::SRC_INIT) begin
                init_pend_q <= 1'b0;
            end
        end

        always_ff @(posedge I_CLK) begin
            if (!I_RST_N) begin
                per_pend_q <= 1'b0;
            end else if (!ctl2_q[p][`CTXSC_CTL2_PERIODIC_BIT]) begin
                per_pend_q <= 1'b0;
            end else if (I_FRAME_END[p]) begin
                per_pend_q <= 1'b1;
            end else if (seq_done && src_q == ctxsc_pkg::SRC_PERIODIC) begin
                per_pend_q <= 1'b0;
            end
        end

        always_ff @(posedge I_CLK) begin
            if (!I_RST_N) begin
                launch_q <= 1'b0;
                src_q <= ctxsc_pkg::SRC_NONE;
            end else begin
                launch_q <= launch;
                if (launch) begin
                    src_q <= src_d;
                end
            end
        end

        // Busy from launch to the done pulse; the start-up cycles before the
        // lanes go active would otherwise let a second launch slip in.
        always_ff @(posedge I_CLK) begin
            if (!I_RST_N) begin
                run_q <= 1'b0;
            end else if (launch) begin
                run_q <= 1'b1;
            end else if (seq_done) begin
                run_q <= 1'b0;
            end
        end

        // The HS engine is held off while initial calibration is owed and
        // while any sequence is on the lanes.
        always_ff @(posedge I_CLK) begin
            if (!I_RST_N) begin
                hold_q <= 1'b0;
            end else begin
                hold_q <= init_pend_q | launch | run_q;
            end
        end
        assign O_HS_HOLD[p] = hold_q;

        ctxsc_cal_seq #(
            .LEN_SHIFT(CAL_LEN_SHIFT)
        ) u_cal_seq (
            .i_clk(I_CLK),
            .i_rst_n(I_RST_N),
            .i_start(launch_q),
            .i_len_code(ctl2_q[p][`CTXSC_CTL2_LEN_HI:`CTXSC_CTL2_LEN_LO]),
            .i_invert(ctl2_q[p][`CTXSC_CTL2_INV_BIT]),
            .o_active(seq_active),
            .o_data(O_CAL_DATA[p]),
            .o_done(seq_done)
        );
        assign O_CAL_ACTIVE[p] = seq_active;

        ctxsc_pass #(
            .NUM_RX(NUM_RX)
        ) u_pass (
            .i_clk(I_CLK),
            .i_rst_n(I_RST_N),
            .i_rx_valid(I_RX_VALID[p*NUM_RX +: NUM_RX]),
            .i_rx_enabled(I_RX_ENABLED[p*NUM_RX +: NUM_RX]),
            .i_all_mode(ctl2_q[p][`CTXSC_CTL2_PASS_MODE_BIT]),
            .i_sync_fwd(I_FWD_SYNC_EN[p]),
            .i_tx_error(I_TX_ERROR[p]),
            .o_pass(O_TX_PASS[p])
        );

        always_ff @(posedge I_CLK) begin
            if (!I_RST_N) begin
                sync_q[p] <= 1'b0;
            end else begin
                sync_q[p] <= I_FWD_SYNC_EN[p] &
                    I_STREAMS_SYNCED[p];
            end
        end
        assign O_TX_SYNC[p] = sync_q[p];
    end

    always_comb begin
        rdata_d = `CTXSC_RD_ZERO;
        case (I_REG_ADDR)
            `CTXSC_ADDR_PORT_SEL: rdata_d = port_sel_q;
            `CTXSC_ADDR_CTL: begin
                rdata_d[`CTXSC_CTL_INIT_CAL_BIT] =
                    init_en_q[read_port];
            end
            `CTXSC_ADDR_CTL2: rdata_d = ctl2_q[read_port];
            `CTXSC_ADDR_STS: begin
                rdata_d[`CTXSC_STS_PORT_NUM_BIT] = read_port;
                rdata_d[`CTXSC_STS_SYNC_BIT] = sync_q[read_port];
                rdata_d[`CTXSC_STS_PASS_BIT] = O_TX_PASS[read_port];
            end
            default: rdata_d = `CTXSC_RD_ZERO;
        endcase
    end

    // Read data is registered so it stays stable for the serial control port.
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_REG_RDATA <= `CTXSC_RD_ZERO;
            O_REG_RVALID <= 1'b0;
        end else begin
            O_REG_RVALID <= I_REG_RD;
            if (I_REG_RD) begin
                O_REG_RDATA <= rdata_d;
            end
        end
    end
endmodule
